// File: logic/rtf_pkg.sv
// rtf_pkg: register map, field layout and reset values of the rate event filter
// assumes word-aligned AHB-Lite access; offsets are register indices times four
package rtf_pkg;
  localparam int unsigned ADDR_W        = 8;
  // printed register indices (not all multiples of four)
  localparam logic [7:0]  IDX_THS_YL    = 8'h35;
  localparam logic [7:0]  IDX_THS_ZH    = 8'h36;
  localparam logic [7:0]  IDX_THS_ZL    = 8'h37;
  localparam logic [7:0]  IDX_DURATION  = 8'h38;
  // own indices for configuration, source status, mask, other thresholds
  localparam logic [7:0]  IDX_CFG       = 8'h30;
  localparam logic [7:0]  IDX_SRC       = 8'h31;
  localparam logic [7:0]  IDX_THS_XH    = 8'h32;
  localparam logic [7:0]  IDX_THS_XL    = 8'h33;
  localparam logic [7:0]  IDX_THS_YH    = 8'h34;
  localparam logic [7:0]  IDX_MASK      = 8'h39;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int unsigned DUR_WAIT_BIT  = 7;
  localparam int unsigned DUR_CNT_W     = 7;
  localparam int unsigned CFG_AND_BIT   = 7;
  localparam int unsigned CFG_LIR_BIT   = 6;
  localparam int unsigned SRC_IA_BIT    = 6;
  localparam int unsigned HI_BYTE_W     = 7;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
endpackage

// File: logic/rtf_axis_cmp.sv
// rtf_axis_cmp: compares one axis magnitude against its 15-bit threshold
// assumes samples are sign-magnitude-free two's complement, valid on sample strobe
`timescale 1ns/100ps
module rtf_axis_cmp #(
  parameter int unsigned DW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          sample_stb,
  input  wire logic [DW-1:0] sample,
  input  wire logic [14:0]   threshold,
  output logic               above_r,
  output logic               below_r
);
  logic [DW-1:0] mag;
  assign mag = sample[DW-1] ? DW'(-sample) : sample;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      above_r <= 1'b0;
      below_r <= 1'b0;
    end else if (sample_stb) begin
      above_r <= mag > DW'(threshold);
      below_r <= mag <= DW'(threshold);
    end
  end
endmodule

// File: logic/rtf_dur_filter.sv
// rtf_dur_filter: duration qualifier of the combined event, counted in samples
// assumes sample_stb pulses once per output sample, at the output data rate
`timescale 1ns/100ps
module rtf_dur_filter #(
  parameter int unsigned CW = 7
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          sample_stb,
  input  wire logic          cond,
  input  wire logic [CW-1:0] dur,
  input  wire logic          wait_en,
  output logic               event_r,
  output logic [CW-1:0]      cnt_r
);
  logic          rise_ok;
  logic          fall_ok;
  logic [CW-1:0] cnt_nxt;
  logic          event_nxt;

  // counting advances only on samples, so a step lasts one sample period
  assign rise_ok = cond && !event_r && (cnt_r >= dur);
  assign fall_ok = !cond && event_r && (!wait_en || cnt_r >= dur);
  assign event_nxt = rise_ok ? 1'b1 : (fall_ok ? 1'b0 : event_r);
  // restart whenever the condition agrees with the present state
  assign cnt_nxt = (cond == event_r || rise_ok || fall_ok) ? '0 :
                   ((&cnt_r) ? cnt_r : cnt_r + 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_r <= 1'b0;
      cnt_r   <= '0;
    end else if (sample_stb) begin
      event_r <= event_nxt;
      cnt_r   <= cnt_nxt;
    end
  end
endmodule

// File: logic/rtf_event_filter.sv
// rtf_event_filter: rate threshold interrupt generator with AHB-Lite registers
// assumes one AHB-Lite master, samples with a strobe at the output data rate
// What this block does
// - Y low, Z high and Z low threshold bytes reset to zero.
// - duration register top bit is wait enable, reset zero.
// - seven-bit duration sets minimum event length in samples, reset zero.
// - duration steps advance once per sample, so scale with data rate.
// - wait off: interrupt falls as soon as signal crosses back.
// - wait on: interrupt falls only after duration samples elapse.
// - per-axis high/low enables, combined by OR or AND selection.
// - latched request holds until the source status is read.
// - source read clears active flag and line, lets latched contents refresh.
`timescale 1ns/100ps
module rtf_event_filter #(
  parameter int unsigned DW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          sample_stb,
  input  wire logic [DW-1:0] rate_x,
  input  wire logic [DW-1:0] rate_y,
  input  wire logic [DW-1:0] rate_z,
  output logic               interrupt_line_one,
  output logic               irq
);
  localparam int unsigned CW = rtf_pkg::DUR_CNT_W;

  // registers
  logic [7:0]    cfg_r;
  logic [6:0]    x_thr_hi_r;
  logic [7:0]    x_thr_lo_r;
  logic [6:0]    y_thr_hi_r;
  logic [7:0]    y_threshold_lower_bits;
  logic [6:0]    z_threshold_upper_bits;
  logic [7:0]    z_threshold_lower_bits;
  logic [7:0]    dur_ctl_r;
  logic [7:0]    mask_r;
  logic [6:0]    src_r;
  logic          interrupt_active_flag;
  logic          line_r;
  logic          irq_r;
  logic [31:0]   hrdata_r;

  // bus address phase
  logic          ph_wr_r;
  logic          ph_rd_r;
  logic [7:0]    ph_idx_r;
  logic          addr_ok;
  logic          wr_en;
  logic          rd_en;
  logic [7:0]    a_idx;
  logic          src_read;

  assign addr_ok = haddr[1:0] == 2'h0 && haddr[31:10] == 22'h0;
  assign a_idx   = haddr[9:2];
  assign wr_en   = hsel && hready && htrans == rtf_pkg::HTRANS_NONSEQ && hwrite && addr_ok;
  assign rd_en   = hsel && hready && htrans == rtf_pkg::HTRANS_NONSEQ && !hwrite && addr_ok;
  assign src_read = rd_en && a_idx == rtf_pkg::IDX_SRC;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r  <= 1'b0;
      ph_rd_r  <= 1'b0;
      ph_idx_r <= rtf_pkg::RST_BYTE;
    end else begin
      ph_wr_r  <= wr_en;
      ph_rd_r  <= rd_en;
      ph_idx_r <= a_idx;
    end
  end

  // write data phase
  logic          dwr;
  logic [7:0]    wb;
  assign dwr = ph_wr_r;
  assign wb  = hwdata[7:0];

  function automatic logic wsel(input logic en, input logic [7:0] idx, input logic [7:0] tgt);
    return en && idx == tgt;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r                  <= rtf_pkg::RST_BYTE;
      x_thr_hi_r             <= 7'h00;
      x_thr_lo_r             <= rtf_pkg::RST_BYTE;
      y_thr_hi_r             <= 7'h00;
      y_threshold_lower_bits <= rtf_pkg::RST_BYTE;
      z_threshold_upper_bits <= 7'h00;
      z_threshold_lower_bits <= rtf_pkg::RST_BYTE;
      dur_ctl_r              <= rtf_pkg::RST_BYTE;
      mask_r                 <= rtf_pkg::RST_BYTE;
    end else begin
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_CFG))      cfg_r <= wb;
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_XH))   x_thr_hi_r <= wb[6:0];
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_XL))   x_thr_lo_r <= wb;
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_YH))   y_thr_hi_r <= wb[6:0];
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_YL))   y_threshold_lower_bits <= wb;
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_ZH))   z_threshold_upper_bits <= wb[6:0];
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_THS_ZL))   z_threshold_lower_bits <= wb;
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_DURATION)) dur_ctl_r <= wb;
      if (wsel(dwr, ph_idx_r, rtf_pkg::IDX_MASK))     mask_r <= wb;
    end
  end

  // comparators
  logic [5:0]    cmp;
  rtf_axis_cmp #(.DW(DW)) u_cmp_x (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sample_stb (sample_stb),
    .sample     (rate_x),
    .threshold  ({x_thr_hi_r, x_thr_lo_r}),
    .above_r    (cmp[1]),
    .below_r    (cmp[0])
  );
  rtf_axis_cmp #(.DW(DW)) u_cmp_y (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sample_stb (sample_stb),
    .sample     (rate_y),
    .threshold  ({y_thr_hi_r, y_threshold_lower_bits}),
    .above_r    (cmp[3]),
    .below_r    (cmp[2])
  );
  rtf_axis_cmp #(.DW(DW)) u_cmp_z (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sample_stb (sample_stb),
    .sample     (rate_z),
    .threshold  ({z_threshold_upper_bits, z_threshold_lower_bits}),
    .above_r    (cmp[5]),
    .below_r    (cmp[4])
  );

  // combine enabled events
  logic [5:0]    enabled;
  logic          cond;
  logic          and_mode;
  logic          latch_request_select;
  assign enabled  = cfg_r[5:0];
  assign and_mode = cfg_r[rtf_pkg::CFG_AND_BIT];
  assign latch_request_select = cfg_r[rtf_pkg::CFG_LIR_BIT];
  assign cond = (enabled != 6'h00) &&
                (and_mode ? ((cmp & enabled) == enabled) : ((cmp & enabled) != 6'h00));

  // duration filter, steps one per sample
  logic          ev;
  logic [CW-1:0] dur_cnt;
  logic          comp_stb_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) comp_stb_r <= 1'b0;
    else          comp_stb_r <= sample_stb;
  end

  rtf_dur_filter #(.CW(CW)) u_dur (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sample_stb (comp_stb_r),
    .cond       (cond),
    .dur        (dur_ctl_r[CW-1:0]),
    .wait_en    (dur_ctl_r[rtf_pkg::DUR_WAIT_BIT]),
    .event_r    (ev),
    .cnt_r      (dur_cnt)
  );

  // source status and line; a new event beats a clearing read
  logic          ev_d_r;
  logic          ev_rise;
  logic          src_frozen;
  logic          ia_nxt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_d_r <= 1'b0;
    else          ev_d_r <= ev;
  end
  assign ev_rise    = ev && !ev_d_r;
  assign src_frozen = latch_request_select && interrupt_active_flag && !src_read;
  assign ia_nxt = latch_request_select ?
                  (ev_rise || (interrupt_active_flag && !src_read)) :
                  (ev && !(src_read && !ev_rise));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_active_flag <= 1'b0;
      src_r                 <= 7'h00;
      line_r                <= 1'b0;
    end else begin
      interrupt_active_flag <= ia_nxt;
      line_r                <= ia_nxt;
      if (!src_frozen) src_r <= {ia_nxt, cmp & enabled};
    end
  end

  // masked interrupt from the sticky status
  logic [7:0]    status_view;
  assign status_view = {1'b0, interrupt_active_flag, src_r[5:0]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_r <= 1'b0;
    else          irq_r <= (ia_nxt && mask_r[rtf_pkg::SRC_IA_BIT]) ||
                           ((src_r[5:0] & mask_r[5:0]) != 6'h00 && interrupt_active_flag);
  end

  // read mux, sampled in the address phase, ready in the data phase
  logic [7:0]    rd_byte;
  always_comb begin
    rd_byte = rtf_pkg::RST_BYTE;
    unique case (a_idx)
      rtf_pkg::IDX_CFG:      rd_byte = cfg_r;
      rtf_pkg::IDX_SRC:      rd_byte = status_view;
      rtf_pkg::IDX_THS_XH:   rd_byte = {1'b0, x_thr_hi_r};
      rtf_pkg::IDX_THS_XL:   rd_byte = x_thr_lo_r;
      rtf_pkg::IDX_THS_YH:   rd_byte = {1'b0, y_thr_hi_r};
      rtf_pkg::IDX_THS_YL:   rd_byte = y_threshold_lower_bits;
      rtf_pkg::IDX_THS_ZH:   rd_byte = {1'b0, z_threshold_upper_bits};
      rtf_pkg::IDX_THS_ZL:   rd_byte = z_threshold_lower_bits;
      rtf_pkg::IDX_DURATION: rd_byte = dur_ctl_r;
      rtf_pkg::IDX_MASK:     rd_byte = mask_r;
      default:               rd_byte = rtf_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_r <= rtf_pkg::RDATA_ZERO;
    else if (rd_en) hrdata_r <= {24'h00_0000, rd_byte};
  end

  // bus response regs: zero wait states, always OKAY
  logic          hreadyout_r;
  logic          hresp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata             = hrdata_r;
  assign hreadyout          = hreadyout_r;
  assign hresp              = hresp_r;
  assign interrupt_line_one = line_r;
  assign irq                = irq_r;

  // checks
  chk_reset_thr_zero: assert property (@(posedge hclk) $rose(hresetn) |->
    y_threshold_lower_bits == 8'h00 && z_threshold_upper_bits == 7'h00 &&
    z_threshold_lower_bits == 8'h00)
    else $error("threshold bytes not zero after reset");
  chk_reset_dur_zero: assert property (@(posedge hclk) $rose(hresetn) |->
    dur_ctl_r == 8'h00)
    else $error("duration register not zero after reset");
  chk_rise_after_dur: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ev) |-> $past(dur_cnt) >= $past(dur_ctl_r[CW-1:0]))
    else $error("event rose before duration reached");
  chk_dur_steps_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(comp_stb_r) |-> $stable(dur_cnt))
    else $error("duration counter moved without a sample");
  chk_nowait_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    comp_stb_r && ev && !cond && !dur_ctl_r[rtf_pkg::DUR_WAIT_BIT] |=> !ev)
    else $error("event did not fall at once with wait off");
  chk_wait_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    comp_stb_r && ev && dur_ctl_r[rtf_pkg::DUR_WAIT_BIT] && dur_cnt < dur_ctl_r[CW-1:0] |=> ev)
    else $error("event fell before duration with wait on");
  chk_cnt_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    comp_stb_r && cond == ev |=> dur_cnt == '0)
    else $error("duration counter did not restart");
  chk_and_combine: assert property (@(posedge hclk) disable iff (!hresetn)
    and_mode && enabled != 6'h00 && (cmp & enabled) != enabled |-> !cond)
    else $error("and combination asserted with missing event");
  chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    latch_request_select && interrupt_active_flag && !src_read |=> interrupt_active_flag)
    else $error("latched request dropped without read");

  // steps of the line and flag behaviour
  sequence s_nowait_drop;
    comp_stb_r && ev && !cond && !dur_ctl_r[rtf_pkg::DUR_WAIT_BIT] && !latch_request_select;
  endsequence
  sequence s_line_falls;
    !ev ##1 !line_r;
  endsequence
  sequence s_latched_set;
    latch_request_select && ev_rise;
  endsequence
  sequence s_flag_and_line;
    interrupt_active_flag && line_r;
  endsequence
  sequence s_src_read_clean;
    src_read && !ev_rise;
  endsequence
  sequence s_flag_line_clear;
    !interrupt_active_flag && !line_r;
  endsequence

  chk_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    s_src_read_clean |=> s_flag_line_clear)
    else $error("source read did not clear active flag");
  chk_nowait_line: assert property (@(posedge hclk) disable iff (!hresetn)
    s_nowait_drop |=> s_line_falls)
    else $error("line did not fall with wait off");
  chk_latch_set: assert property (@(posedge hclk) disable iff (!hresetn)
    s_latched_set |=> s_flag_and_line)
    else $error("latched event did not raise flag and line");
  chk_src_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    latch_request_select && interrupt_active_flag && !src_read |=> $stable(src_r[5:0]))
    else $error("latched source bits changed before read");
  chk_read_before_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    src_read |=> hrdata_r[rtf_pkg::SRC_IA_BIT] == $past(interrupt_active_flag))
    else $error("source read did not return flag before clear");
  chk_zero_dur_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    comp_stb_r && cond && !ev && dur_ctl_r[CW-1:0] == '0 |=> ev)
    else $error("event did not rise at once with zero duration");
  chk_or_combine: assert property (@(posedge hclk) disable iff (!hresetn)
    !and_mode && (cmp & enabled) != 6'h00 |-> cond)
    else $error("or combination missed an enabled event");
  chk_and_match: assert property (@(posedge hclk) disable iff (!hresetn)
    and_mode && enabled != 6'h00 && (cmp & enabled) == enabled |-> cond)
    else $error("and combination missed all enabled events");
  chk_dur_write: assert property (@(posedge hclk) disable iff (!hresetn)
    dwr && ph_idx_r == rtf_pkg::IDX_DURATION |=> dur_ctl_r == $past(wb))
    else $error("duration register write lost");
  chk_zh_write: assert property (@(posedge hclk) disable iff (!hresetn)
    dwr && ph_idx_r == rtf_pkg::IDX_THS_ZH |=> z_threshold_upper_bits == $past(wb[6:0]))
    else $error("z upper threshold write lost");
  chk_yl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    dwr && ph_idx_r == rtf_pkg::IDX_THS_YL |=> y_threshold_lower_bits == $past(wb))
    else $error("y lower threshold write lost");
  chk_irq_masked_off: assert property (@(posedge hclk) disable iff (!hresetn)
    mask_r == rtf_pkg::RST_BYTE |=> !irq_r)
    else $error("interrupt raised with all bits masked");
endmodule

// File: sim/rtf_host_model.sv
// rtf_host_model: AHB-Lite master standing in for the host processor
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/100ps
module rtf_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = rtf_pkg::HSIZE_WORD;
    hwdata = 32'h0;
  end

  // one single word transfer; byte address is the index times four
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= rtf_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[7:0];
    // released lines carry junk, not the old value
    hsel   <= 1'b0;
    haddr  <= ~haddr;
    hwdata <= ~hwdata;
  endtask
endmodule

// File: sim/tb.sv
// tb: self-checking bench of the rate event filter
// assumes host_u as bus master; samples driven here at the output data rate
`timescale 1ns/100ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        stb;
  logic [15:0] rx;
  logic [15:0] ry;
  logic [15:0] rz;
  logic        line;
  logic        irq;
  int          err_total;
  int          samples_checked;

  rtf_event_filter #(.DW(16)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_stb(stb),
    .rate_x(rx), .rate_y(ry), .rate_z(rz), .interrupt_line_one(line), .irq(irq));

  rtf_host_model host_u (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] junk;
    host_u.xfer(idx, 1'b1, d, junk);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    host_u.xfer(idx, 1'b0, 8'h00, d);
    #1;
  endtask

  // n sample pulses, each followed by time for the line to settle
  task automatic smp(input logic [15:0] y, input logic [15:0] z, input int n);
    repeat (n) begin
      @(posedge hclk);
      stb <= 1'b1;
      ry  <= y;
      rz  <= z;
      @(posedge hclk);
      stb <= 1'b0;
      ry  <= ~y;
      rz  <= ~z;
      repeat (6) @(posedge hclk);
    end
    #1;
  endtask

  task automatic t_regs;
    logic [7:0] idx [4];
    logic [7:0] wv [4];
    logic [7:0] v;
    idx = '{8'h35, 8'h36, 8'h37, 8'h38};
    wv  = '{8'hA5, 8'h5A, 8'hC3, 8'h81};
    for (int i = 0; i < 4; i++) begin
      rd(idx[i], v);
      chk("reset value", v, rtf_pkg::RST_BYTE);
      wr(idx[i], wv[i]);
      rd(idx[i], v);
      chk("readback", v, wv[i]);
    end
    wr(8'h3C, 8'hFF);
    rd(8'h3C, v);
    chk("unmapped", v, 8'h00);
    chk("hresp", hresp, 1'b0);
  endtask

  task automatic t_nowait;
    wr(rtf_pkg::IDX_THS_YH, 8'h00);
    wr(rtf_pkg::IDX_THS_YL, 8'h10);
    wr(rtf_pkg::IDX_DURATION, 8'h00);
    wr(rtf_pkg::IDX_CFG, 8'h08);
    smp(16'd100, 16'd0, 1);
    chk("y high raise", line, 1'b1);
    smp(16'd5, 16'd0, 1);
    chk("y back fall", line, 1'b0);
  endtask

  task automatic t_dur;
    wr(rtf_pkg::IDX_DURATION, 8'h03);
    smp(16'd100, 16'd0, 1);
    chk("short event", line, 1'b0);
    repeat (30) @(posedge hclk);
    #1;
    chk("no sample no count", line, 1'b0);
    smp(16'd5, 16'd0, 1);
    smp(16'd100, 16'd0, 2);
    chk("count restart", line, 1'b0);
    smp(16'd100, 16'd0, 3);
    chk("long event", line, 1'b1);
    smp(16'd5, 16'd0, 1);
    chk("fall no wait", line, 1'b0);
  endtask

  task automatic t_wait;
    wr(rtf_pkg::IDX_DURATION, 8'h83);
    smp(16'd100, 16'd0, 5);
    chk("wait raise", line, 1'b1);
    smp(16'd5, 16'd0, 1);
    chk("wait hold", line, 1'b1);
    smp(16'd5, 16'd0, 4);
    chk("wait fall", line, 1'b0);
  endtask

  task automatic t_comb;
    wr(rtf_pkg::IDX_DURATION, 8'h00);
    wr(rtf_pkg::IDX_THS_ZH, 8'h00);
    wr(rtf_pkg::IDX_THS_ZL, 8'h10);
    wr(rtf_pkg::IDX_CFG, 8'hA8);
    smp(16'd100, 16'd0, 1);
    chk("and one", line, 1'b0);
    smp(16'd100, 16'd100, 1);
    chk("and both", line, 1'b1);
    wr(rtf_pkg::IDX_CFG, 8'h10);
    smp(16'd100, 16'd100, 1);
    chk("z low off", line, 1'b0);
    smp(16'd100, 16'd5, 1);
    chk("z low", line, 1'b1);
  endtask

  task automatic t_latch;
    logic [7:0] v;
    wr(rtf_pkg::IDX_CFG, 8'h00);
    smp(16'd5, 16'd5, 1);
    rd(rtf_pkg::IDX_SRC, v);
    wr(rtf_pkg::IDX_MASK, 8'h40);
    wr(rtf_pkg::IDX_CFG, 8'h48);
    smp(16'd100, 16'd0, 1);
    smp(16'd5, 16'd0, 1);
    chk("latched line", line, 1'b1);
    chk("irq raised", irq, 1'b1);
    wr(rtf_pkg::IDX_MASK, 8'h00);
    repeat (2) @(posedge hclk);
    #1;
    chk("irq masked", irq, 1'b0);
    wr(rtf_pkg::IDX_MASK, 8'h40);
    rd(rtf_pkg::IDX_SRC, v);
    chk("source", v, 8'h48);
    repeat (2) @(posedge hclk);
    #1;
    chk("line cleared", line, 1'b0);
    chk("irq cleared", irq, 1'b0);
    rd(rtf_pkg::IDX_SRC, v);
    chk("flag cleared", v & 8'h40, 8'h00);
  endtask

  initial begin
    err_total       = 0;
    samples_checked = 0;
    hresetn         = 1'b0;
    stb             = 1'b0;
    rx              = 16'h0000;
    ry              = 16'h0000;
    rz              = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_nowait;
    t_dur;
    t_wait;
    t_comb;
    t_latch;
    conclude;
  end

  // whole run is well under 2000 cycles
  initial begin
    #3000000;
    err_total++;
    conclude;
  end
endmodule
